// *** include/cmb_defs.vh ***
// Constants of the CAN message buffer and transmit scheduler.
// Assumes 32-bit APB words, one register per aligned word.
`ifndef CMB_DEFS_VH
`define CMB_DEFS_VH
`define CMB_NBUF 3
`define CMB_MEM_BYTES 39
`define CMB_BUF_BYTES 6'd13
`define CMB_MAX_BYTES 4'h8
// Register indices; byte address is four times the index
`define CMB_IDX_CTRL 5'h00
`define CMB_IDX_FLAG 5'h01
`define CMB_IDX_MASK 5'h02
`define CMB_IDX_ABRQ 5'h03
`define CMB_IDX_ABAK 5'h04
`define CMB_IDX_SEL 5'h05
// Offsets inside the transmit window
`define CMB_OFF_ID1 4'h1
`define CMB_OFF_ID2 4'h2
`define CMB_OFF_ID3 4'h3
`define CMB_OFF_DATA 4'h4
`define CMB_OFF_LEN 4'hc
`define CMB_OFF_LOCAL_PRIORITY_FIELD 4'hd
`define CMB_OFF_STH 4'he
`define CMB_OFF_STL 4'hf
// Field positions and reset values
`define CMB_PADDR_WIN 6
`define CMB_PADDR_HIGH 7
`define CMB_CTRL_INIT 0
`define CMB_CTRL_TIME 1
`define CMB_ID1_EXT 3
`define CMB_ID1_RTR_STD 4
`define CMB_ID3_RTR_EXT 0
`define CMB_LOCAL_PRIORITY_FIELD_RESET 8'h00
`define CMB_EMPTY_RESET 3'h7
`endif

// *** design/cmb_tx_buffers.v ***
// Transmit buffers, local priority scheduling, abort and time stamps.
// Assumes a CAN protocol engine on the link side that pulses arbitration
// start, completion, failure, ACK delimiter sample and bit ticks.
// Overview of operation
// - Remote-request bit selects remote (1) or data (0) frame to send.
// - Eight payload bytes per buffer; only length-code bytes are sent.
// - Length code is a 4-bit binary byte count; codes above 8 send eight bytes.
// - Remote frames send the length code unchanged but no payload.
// - Eight-bit local priority; smaller value wins.
// - Before start of frame all non-empty buffers without a pending abort request compete; lowest wins.
// - Equal lowest priorities resolve to the lowest buffer index.
// - With stamping on, timer goes into stamp at ACK delimiter sample.
// - Stamp timer free-runs on bit clock; wrap is not reported.
// - Stamp timer held at zero in initialization mode.
// - Stamp registers are read-only; only hardware writes them.
// - Exactly three transmit buffers for back to back frames.
// - Successful send sets empty flag and raises unmasked interrupt.
// - Scheduling reruns on every arbitration, including retries.
// - Abort request honoured unless sending: ack, empty, interrupt.
// - Abort acknowledge reads 1 if aborted, 0 if sent.
// - Buffer spans sixteen bytes; last two hold the 16-bit stamp.
// - Local priorities reset to zero; other contents undefined.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "cmb_defs.vh"
module cmb_tx_buffers
(
    input wire CLK_SYS,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire ARB_START,
    input wire TX_DONE,
    input wire TX_FAIL,
    input wire ACK_DELIM_SAMPLE,
    input wire BIT_TICK,
    input wire [2:0] PAYLOAD_SEL,
    output reg TX_VALID,
    output reg [1:0] TX_BUF_SEL,
    output reg [31:0] TX_ID,
    output reg TX_EXT,
    output reg TX_RTR,
    output reg [3:0] TX_DLC,
    output reg [3:0] TX_BYTE_COUNT,
    output reg [7:0] TX_DATA,
    output reg TX_IRQ,
    output wire INIT_MODE
);
    reg [7:0] mem [0:`CMB_MEM_BYTES-1];
    reg [7:0] local_priority_field [0:`CMB_NBUF-1];
    reg [15:0] stamp [0:`CMB_NBUF-1];
    reg [1:0] ctrl;
    reg [2:0] empty;
    reg [2:0] mask;
    reg [2:0] abort_req;
    reg [2:0] abort_ack;
    reg [2:0] sel;
    reg [15:0] timer;
    reg busy;
    reg [1:0] act;
    reg [2:0] act_mask;
    wire [2:0] next_empty;
    wire [2:0] next_ack;
    wire [2:0] next_req;
    wire [2:0] abort_now;
    reg [2:0] done_mask;
    reg [2:0] next_sel;
    reg [1:0] win;
    reg win_found;
    reg [7:0] win_local_priority_field;
    reg [1:0] sel_idx;
    reg [31:0] rd_val;
    reg rd_ok;
    integer i;
    wire setup = PSEL & ~PENABLE;
    wire wr = PSEL & PENABLE & PWRITE;
    wire win_hit = PADDR[`CMB_PADDR_WIN];
    wire [4:0] idx = PADDR[6:2];
    wire [3:0] off = PADDR[5:2];
    wire [2:0] flag_clr = (wr && !win_hit && idx == `CMB_IDX_FLAG) ? PWDATA[2:0] : 3'h0;
    wire [2:0] req_set = (wr && !win_hit && idx == `CMB_IDX_ABRQ) ? PWDATA[2:0] : 3'h0;
    wire [5:0] sel_base;
    wire [5:0] win_base;
    wire [5:0] act_base;
    wire sel_any = |sel;
    wire sel_wr_ok = |(sel & empty);
    wire [7:0] win_id1 = mem[win_base + {2'b00, `CMB_OFF_ID1}];
    wire [7:0] win_id3 = mem[win_base + {2'b00, `CMB_OFF_ID3}];
    wire [3:0] win_len = mem[win_base + {2'b00, `CMB_OFF_LEN}][3:0];
    wire win_ext = win_id1[`CMB_ID1_EXT];
    wire win_rtr = win_ext ? win_id3[`CMB_ID3_RTR_EXT] : win_id1[`CMB_ID1_RTR_STD];

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~rd_ok;
    assign INIT_MODE = ctrl[`CMB_CTRL_INIT];

    cmb_buf_base u_sel_base
    (
        .buf_idx(sel_idx),
        .base(sel_base)
    );

    cmb_buf_base u_win_base
    (
        .buf_idx(win),
        .base(win_base)
    );

    cmb_buf_base u_act_base
    (
        .buf_idx(act),
        .base(act_base)
    );

    always @*
    begin
        sel_idx = 2'd0;
        if (sel[1])
            sel_idx = 2'd1;
        if (sel[2])
            sel_idx = 2'd2;
    end

    // Lowest value wins; strict compare keeps the lower index on ties
    always @*
    begin
        win = 2'd0;
        win_found = 1'b0;
        win_local_priority_field = 8'h00;
        for (i = 0; i < `CMB_NBUF; i = i + 1)
        begin
            if (!empty[i] && !abort_req[i] && (!win_found || local_priority_field[i] < win_local_priority_field))
            begin
                win = i[1:0];
                win_found = 1'b1;
                win_local_priority_field = local_priority_field[i];
            end
        end
    end

    always @*
    begin
        act_mask = 3'h0;
        act_mask[act] = busy;
        done_mask = TX_DONE ? act_mask : 3'h0;
    end

    cmb_flag_cell u_flag_0
    (
        .empty(empty[0]),
        .ack(abort_ack[0]),
        .req(abort_req[0]),
        .clr(flag_clr[0]),
        .req_set(req_set[0]),
        .done(done_mask[0]),
        .active(act_mask[0]),
        .next_empty(next_empty[0]),
        .next_ack(next_ack[0]),
        .next_req(next_req[0]),
        .abort_now(abort_now[0])
    );

    cmb_flag_cell u_flag_1
    (
        .empty(empty[1]),
        .ack(abort_ack[1]),
        .req(abort_req[1]),
        .clr(flag_clr[1]),
        .req_set(req_set[1]),
        .done(done_mask[1]),
        .active(act_mask[1]),
        .next_empty(next_empty[1]),
        .next_ack(next_ack[1]),
        .next_req(next_req[1]),
        .abort_now(abort_now[1])
    );

    cmb_flag_cell u_flag_2
    (
        .empty(empty[2]),
        .ack(abort_ack[2]),
        .req(abort_req[2]),
        .clr(flag_clr[2]),
        .req_set(req_set[2]),
        .done(done_mask[2]),
        .active(act_mask[2]),
        .next_empty(next_empty[2]),
        .next_ack(next_ack[2]),
        .next_req(next_req[2]),
        .abort_now(abort_now[2])
    );

    always @*
    begin
        next_sel = sel & next_empty;
        if (wr && !win_hit && idx == `CMB_IDX_SEL)
        begin
            next_sel = 3'h0;
            // Only the lowest requested empty buffer is mapped
            for (i = `CMB_NBUF - 1; i >= 0; i = i - 1)
            begin
                if (PWDATA[i] && empty[i])
                    next_sel = 3'h1 << i;
            end
        end
    end

    always @*
    begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        if (win_hit)
        begin
            if (!sel_any)
                rd_val = 32'h0;
            else if (off == `CMB_OFF_LOCAL_PRIORITY_FIELD)
                rd_val[7:0] = local_priority_field[sel_idx];
            else if (off == `CMB_OFF_STH)
                rd_val[7:0] = stamp[sel_idx][15:8];
            else if (off == `CMB_OFF_STL)
                rd_val[7:0] = stamp[sel_idx][7:0];
            else
                rd_val[7:0] = mem[sel_base + {2'b00, off}];
        end
        else if (PADDR[`CMB_PADDR_HIGH])
            rd_ok = 1'b0;
        else
        begin
            case (idx)
                `CMB_IDX_CTRL: rd_val[1:0] = ctrl;
                `CMB_IDX_FLAG: rd_val[2:0] = empty;
                `CMB_IDX_MASK: rd_val[2:0] = mask;
                `CMB_IDX_ABRQ: rd_val[2:0] = abort_req;
                `CMB_IDX_ABAK: rd_val[2:0] = abort_ack;
                `CMB_IDX_SEL: rd_val[2:0] = sel;
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // Buffer body is plain storage with no reset
    always @(posedge CLK_SYS)
    begin
        if (wr && win_hit && sel_wr_ok && off < `CMB_OFF_LOCAL_PRIORITY_FIELD)
            mem[sel_base + {2'b00, off}] <= PWDATA[7:0];
    end

    always @(posedge CLK_SYS)
    begin
        for (i = 0; i < `CMB_NBUF; i = i + 1)
        begin
            if (RST)
                local_priority_field[i] <= `CMB_LOCAL_PRIORITY_FIELD_RESET;
            else if (wr && win_hit && sel_wr_ok && off == `CMB_OFF_LOCAL_PRIORITY_FIELD && sel_idx == i[1:0])
                local_priority_field[i] <= PWDATA[7:0];
            // Stamp has no software write path at all
            if (ACK_DELIM_SAMPLE && busy && ctrl[`CMB_CTRL_TIME] && act == i[1:0])
                stamp[i] <= timer;
        end
    end

    always @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ctrl <= 2'h0;
            empty <= `CMB_EMPTY_RESET;
            mask <= 3'h0;
            abort_req <= 3'h0;
            abort_ack <= 3'h0;
            sel <= 3'h0;
            timer <= 16'h0000;
            PRDATA <= 32'h0;
            TX_IRQ <= 1'b0;
        end
        else
        begin
            if (wr && !win_hit && idx == `CMB_IDX_CTRL)
                ctrl <= PWDATA[1:0];
            if (wr && !win_hit && idx == `CMB_IDX_MASK)
                mask <= PWDATA[2:0];
            empty <= next_empty;
            abort_ack <= next_ack;
            abort_req <= next_req;
            sel <= next_sel;
            // Wraps silently; software must unwrap across overflow
            if (ctrl[`CMB_CTRL_INIT])
                timer <= 16'h0000;
            else if (BIT_TICK)
                timer <= timer + 16'h0001;
            if (setup)
                PRDATA <= rd_val;
            TX_IRQ <= |(next_empty & mask);
        end
    end

    // One winner latched per arbitration, retries included
    always @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            busy <= 1'b0;
            act <= 2'd0;
            TX_VALID <= 1'b0;
            TX_BUF_SEL <= 2'd0;
            TX_ID <= 32'h0;
            TX_EXT <= 1'b0;
            TX_RTR <= 1'b0;
            TX_DLC <= 4'h0;
            TX_BYTE_COUNT <= 4'h0;
            TX_DATA <= 8'h00;
        end
        else
        begin
            if (ARB_START && !ctrl[`CMB_CTRL_INIT])
            begin
                busy <= win_found;
                act <= win;
                TX_VALID <= win_found;
                TX_BUF_SEL <= win;
                TX_ID <= {mem[win_base], win_id1, mem[win_base + {2'b00, `CMB_OFF_ID2}], win_id3};
                TX_EXT <= win_ext;
                TX_RTR <= win_rtr;
                TX_DLC <= win_len;
                if (win_rtr)
                    TX_BYTE_COUNT <= 4'h0;
                else if (win_len > `CMB_MAX_BYTES)
                    TX_BYTE_COUNT <= `CMB_MAX_BYTES;
                else
                    TX_BYTE_COUNT <= win_len;
            end
            else if (TX_DONE || TX_FAIL || ctrl[`CMB_CTRL_INIT])
            begin
                busy <= 1'b0;
                TX_VALID <= 1'b0;
            end
            TX_DATA <= mem[act_base + {2'b00, `CMB_OFF_DATA} + {3'b000, PAYLOAD_SEL}];
        end
    end
endmodule

// Start of one buffer's slice of the shared byte array
module cmb_buf_base
#(
    parameter [5:0] BUF_BYTES = `CMB_BUF_BYTES
)
(
    input wire [1:0] buf_idx,
    output wire [5:0] base
);
    // Code 3 never names a buffer; it aliases the last one
    assign base = (buf_idx == 2'd0) ? 6'd0 : (buf_idx == 2'd1) ? BUF_BYTES : BUF_BYTES + BUF_BYTES;
endmodule

// Next state of one buffer's empty, abort request and acknowledge bits
module cmb_flag_cell
(
    input wire empty,
    input wire ack,
    input wire req,
    input wire clr,
    input wire req_set,
    input wire done,
    input wire active,
    output wire next_empty,
    output wire next_ack,
    output wire next_req,
    output wire abort_now
);
    wire soft_empty = empty & ~clr;
    // Frame on the wire cannot be withdrawn
    assign abort_now = req & ~empty & ~active;
    // Hardware set beats a same-cycle software clear
    assign next_empty = soft_empty | done | abort_now;
    assign next_ack = (ack & ~clr & ~done) | abort_now;
    // Request lives only while the buffer is pending
    assign next_req = (req | req_set) & ~next_empty;
endmodule

// *** bench/cmb_chk.sv ***
// Port checker for the transmit buffer block.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ns
module cmb_chk
(
    input wire CLK_SYS,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire [7:0] PADDR,
    input wire PSLVERR,
    input wire ARB_START,
    input wire TX_DONE,
    input wire TX_FAIL,
    input wire INIT_MODE,
    input wire TX_VALID,
    input wire [1:0] TX_BUF_SEL,
    input wire TX_RTR,
    input wire [3:0] TX_DLC,
    input wire [3:0] TX_BYTE_COUNT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_bad_addr: assert property (PSEL && PENABLE && PADDR[7:2] == 6'h06 |-> PSLVERR)
        else $error("no slave error");
    a_remote_empty: assert property (TX_VALID && TX_RTR |-> TX_BYTE_COUNT == 4'h0)
        else $error("remote payload");
    a_data_count: assert property (TX_VALID && !TX_RTR |-> TX_BYTE_COUNT == (TX_DLC > 4'h8 ? 4'h8 : TX_DLC))
        else $error("bad byte count");
    a_three_bufs: assert property (TX_VALID |-> TX_BUF_SEL != 2'h3)
        else $error("bad buffer index");
    a_sched_arb: assert property ($rose(TX_VALID) |-> $past(ARB_START))
        else $error("send without arbitration");
    a_done_frees: assert property (TX_VALID && TX_DONE |=> !TX_VALID)
        else $error("sent frame kept");
    a_fail_frees: assert property (TX_VALID && TX_FAIL |=> !TX_VALID)
        else $error("failed frame kept");
    a_hold_pick: assert property (TX_VALID && !(TX_DONE || TX_FAIL || INIT_MODE || ARB_START)
        |=> TX_VALID && $stable(TX_BUF_SEL)) else $error("choice changed");
    cover property (TX_VALID && TX_FAIL);
    cover property (TX_VALID && TX_RTR);
    cover property (TX_VALID && TX_DONE);
endmodule
bind cmb_tx_buffers cmb_chk u_chk (.*);

// *** bench/cmb_engine.sv ***
// Protocol engine stand-in on the link side.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ns
module cmb_engine
(
    input wire clk,
    output logic arb = 1'b0,
    output logic done = 1'b0,
    output logic fail = 1'b0,
    output logic ack = 1'b0,
    output logic tick = 1'b0,
    output logic [2:0] sel = 3'h0
);
    task start;
        @(posedge clk);
        arb <= 1'b1;
        @(posedge clk);
        arb <= 1'b0;
        @(negedge clk);
    endtask
    task pick(input logic [2:0] i);
        @(posedge clk);
        sel <= i;
        @(posedge clk);
        @(negedge clk);
    endtask
    // Ticks only inside frames, so stamps are exact
    task finish(input int n, input logic ok);
        repeat (n)
        begin
            @(posedge clk);
            tick <= 1'b1;
        end
        @(posedge clk);
        tick <= 1'b0;
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        done <= ok;
        fail <= !ok;
        @(posedge clk);
        done <= 1'b0;
        fail <= 1'b0;
    endtask
endmodule

// *** bench/tb_cmb_tx_buffers.sv ***
// Bench for the transmit buffers: APB tasks and frame checks.
// Assumes the engine model drives the link side.
`timescale 1ns/1ns
`include "cmb_defs.vh"
module tb_cmb_tx_buffers;
    localparam logic [5:0] CTRL = {1'b0, `CMB_IDX_CTRL};
    localparam logic [5:0] FLAG = {1'b0, `CMB_IDX_FLAG};
    localparam logic [5:0] MASK = {1'b0, `CMB_IDX_MASK};
    localparam logic [5:0] ABRQ = {1'b0, `CMB_IDX_ABRQ};
    localparam logic [5:0] ABAK = {1'b0, `CMB_IDX_ABAK};
    localparam logic [5:0] SEL = {1'b0, `CMB_IDX_SEL};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic prdy, arb, done, fail, ack, tick, vld, rtr, irq;
    logic [2:0] psl;
    logic [1:0] bsel;
    logic [3:0] dlc, cnt;
    logic [7:0] dat;
    logic [31:0] tid;
    logic ext, init, serr, err;
    int n_errors = 0, checks = 0, cycles = 0, b, i;
    cmb_tx_buffers dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(serr), .ARB_START(arb), .TX_DONE(done),
        .TX_FAIL(fail), .ACK_DELIM_SAMPLE(ack), .BIT_TICK(tick), .PAYLOAD_SEL(psl), .TX_VALID(vld),
        .TX_BUF_SEL(bsel), .TX_ID(tid), .TX_EXT(ext), .TX_RTR(rtr), .TX_DLC(dlc), .TX_BYTE_COUNT(cnt),
        .TX_DATA(dat), .TX_IRQ(irq), .INIT_MODE(init));
    cmb_engine eng (.clk(clk), .arb(arb), .done(done), .fail(fail), .ack(ack), .tick(tick), .sel(psl));
    initial forever #4 clk = ~clk;
    task close_out;
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= {a, 2'b00};
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (prdy !== 1'b1);
        rd = prd;
        err = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rchk(input string n, input logic [5:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    function logic [5:0] win(input logic [3:0] o);
        return {2'b01, o};
    endfunction
    task load(input logic [1:0] s, input logic [7:0] p, input logic [3:0] n, input logic [31:0] id);
        xfer(1'b1, SEL, 32'h1 << s);
        for (i = 0; i < 4; i++)
            xfer(1'b1, win(4'(i)), {24'h0, id[31 - 8 * i -: 8]});
        for (i = 0; i < 8; i++)
            xfer(1'b1, win(4'h4 + 4'(i)), 32'h10 * s + i);
        xfer(1'b1, win(`CMB_OFF_LEN), {28'h0, n});
        xfer(1'b1, win(`CMB_OFF_LOCAL_PRIORITY_FIELD), {24'h0, p});
        xfer(1'b1, FLAG, 32'h1 << s);
    endtask
    task tx(input logic [1:0] s, input logic [3:0] d, input logic r, input logic [3:0] n, input logic [31:0] id,
        input logic e);
        eng.start;
        chk("valid", 32'h1, vld);
        chk("ident", id, tid);
        chk("extended", e, ext);
        chk("buffer", s, bsel);
        chk("length", d, dlc);
        chk("remote", r, rtr);
        chk("count", n, cnt);
        for (i = 0; i < n; i++)
        begin
            eng.pick(i[2:0]);
            chk("data", 32'h10 * s + i, dat);
        end
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            close_out;
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (b = 0; b < 3; b++)
        begin
            xfer(1'b1, SEL, 32'h1 << b);
            rchk("local_priority_field", win(`CMB_OFF_LOCAL_PRIORITY_FIELD), 32'h0);
        end
        load(2'd0, 8'h05, 4'h8, 32'h1120aa55);
        load(2'd1, 8'h02, 4'h3, 32'h22e01234);
        load(2'd2, 8'h02, 4'h5, 32'h33300000);
        rchk("flag", FLAG, 32'h0);
        tx(2'd1, 4'h3, 1'b0, 4'h3, 32'h22e01234, 1'b0);
        eng.finish(2, 1'b0);
        tx(2'd1, 4'h3, 1'b0, 4'h3, 32'h22e01234, 1'b0);
        eng.finish(2, 1'b1);
        rchk("flag", FLAG, 32'h2);
        tx(2'd2, 4'h5, 1'b1, 4'h0, 32'h33300000, 1'b0);
        eng.finish(2, 1'b1);
        tx(2'd0, 4'h8, 1'b0, 4'h8, 32'h1120aa55, 1'b0);
        xfer(1'b1, ABRQ, 32'h1);
        eng.finish(2, 1'b1);
        rchk("ack", ABAK, 32'h0);
        rchk("flag", FLAG, 32'h7);
        xfer(1'b1, MASK, 32'h7);
        repeat (2) @(negedge clk);
        chk("irq", 32'h1, irq);
        load(2'd2, 8'h00, 4'h1, 32'h0);
        xfer(1'b1, ABRQ, 32'h4);
        rchk("ack", ABAK, 32'h4);
        rchk("flag", FLAG, 32'h7);
        xfer(1'b1, CTRL, 32'h1);
        @(negedge clk);
        chk("init", 32'h1, init);
        xfer(1'b1, CTRL, 32'h2);
        load(2'd0, 8'h00, 4'ha, 32'h44185a3e);
        tx(2'd0, 4'ha, 1'b0, 4'h8, 32'h44185a3e, 1'b1);
        eng.finish(3, 1'b1);
        xfer(1'b1, SEL, 32'h1);
        xfer(1'b1, win(`CMB_OFF_STL), 32'haa);
        rchk("stamp", win(`CMB_OFF_STH), 32'h0);
        rchk("stamp", win(`CMB_OFF_STL), 32'h3);
        rchk("unmapped", 6'h06, 32'h0);
        chk("error", 32'h1, err);
        close_out;
    end
endmodule
